// File: logic/msci_pkg.sv
// constants, types and helpers for the serial motion command interpreter
package msci_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_MHZ = 125;
  localparam int BAUD_RATE = 9600;
  localparam logic [15:0] BAUD_DIV_DEF = 16'(CLK_HZ / BAUD_RATE);
  localparam int STEP_PULSE_NS = 2000;
  localparam logic [15:0] STEP_PULSE_CYC =
    16'((STEP_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam int MEM_AW = 11;
  localparam int POS_W = 24;
  localparam int PER_W = 16;
  localparam logic [MEM_AW-1:0] MEM_LAST = 11'h7FF;
  localparam logic [MEM_AW-1:0] FLAG_LAST = 11'h003;
  localparam logic [MEM_AW-1:0] PROG_START = 11'h003;
  localparam logic [MEM_AW-1:0] BOOT_WAIT = 11'h004;
  localparam logic [POS_W-1:0] ENABLE_BIT = 24'h000000;
  localparam logic [POS_W-1:0] HOME_BIT = 24'h000001;
  localparam int MODE_BUSY = 7;
  localparam logic [2:0] DIG_N = 3'h7;
  localparam logic [3:0] Y_OFS = 4'h1;
  localparam logic [3:0] P_OFS = 4'h2;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_Q = 8'h3F;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_Y = 8'h59;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_POS = 8'h08;
  localparam logic [7:0] A_PTR = 8'h0C;
  localparam logic [7:0] A_START = 8'h10;
  localparam logic [7:0] A_TOP = 8'h14;
  localparam logic [7:0] A_ACCEL = 8'h18;
  localparam logic [7:0] A_IRQ_ST = 8'h1C;
  localparam logic [7:0] A_IRQ_MSK = 8'h20;
  localparam logic [PER_W-1:0] START_RST = 16'h30D4;
  localparam logic [PER_W-1:0] TOP_RST = 16'h04E2;
  localparam logic [PER_W-1:0] ACCEL_RST = 16'h0032;
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_HOME = 1;
  localparam int EV_ERASE = 2;
  localparam int EV_LOST = 3;
  typedef enum logic [3:0] {
    ST_BOOT, ST_FLAGS, ST_IDLE, ST_EXEC, ST_CONV, ST_SEND, ST_MOVE,
    ST_HOME, ST_ERASE, ST_RUN
  } msci_state_t;
  typedef enum logic [1:0] {RK_POS, RK_PTR, RK_DONE} msci_reply_t;

  function automatic logic [POS_W-1:0] pow10(logic [2:0] k);
    case (k)
      3'h0: pow10 = 24'h0F4240;
      3'h1: pow10 = 24'h0186A0;
      3'h2: pow10 = 24'h002710;
      3'h3: pow10 = 24'h0003E8;
      3'h4: pow10 = 24'h000064;
      3'h5: pow10 = 24'h00000A;
      default: pow10 = 24'h000001;
    endcase
  endfunction

  // one ramp step: shorter period each step until the top-speed period
  function automatic logic [PER_W-1:0] next_per(logic [PER_W-1:0] per,
      logic [PER_W-1:0] top, logic [PER_W-1:0] acc);
    if ({1'b0, per} > {1'b0, top} + {1'b0, acc}) begin
      next_per = per - acc;
    end else begin
      next_per = top;
    end
  endfunction
endpackage

// File: logic/msci_mem.sv
// byte memory for stored command lines, registered read data
`timescale 1ns/1ns
`default_nettype none
module msci_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [msci_pkg::MEM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  import msci_pkg::*;
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  // no reset: contents are the stored program, kept across resets
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// File: logic/msci_top.sv
// serial motion command interpreter with apb registers
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module msci_top #(
  parameter logic [15:0] BAUD_DIV = msci_pkg::BAUD_DIV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic ready_busy,
  output logic busy_bit,
  input wire logic home_sensor,
  input wire logic autostart_lockout,
  output logic step,
  output logic dir_cw,
  output logic drv_enable_n,
  output logic irq
);
  import msci_pkg::*;

  function automatic logic [7:0] reply_char(msci_reply_t kind,
      logic [3:0] idx, logic [4*7-1:0] dig);
    logic [3:0] k;
    k = (kind == RK_POS) ? idx - P_OFS : idx + Y_OFS;
    reply_char = CH_CR;
    if (kind == RK_DONE) begin
      case (idx)
        4'h0: reply_char = CH_D;
        4'h1: reply_char = CH_O;
        4'h2: reply_char = CH_N;
        4'h3: reply_char = CH_E;
        default: reply_char = CH_CR;
      endcase
    end else if (idx == 4'h0) begin
      reply_char = (kind == RK_POS) ? CH_P : CH_Y;
    end else if (idx == 4'h1) begin
      reply_char = CH_EQ;
    end else if (k < {1'b0, DIG_N}) begin
      reply_char = CH_0 + {4'h0, dig[{k[2:0], 2'b00} +: 4]};
    end
  endfunction

  // synchronisers, first stage read only by the second
  logic [1:0] rx_s_q, home_s_q, lock_s_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s_q <= 2'b11;
      home_s_q <= 2'b11;
      lock_s_q <= 2'b00;
    end else begin
      rx_s_q <= {rx_s_q[0], rxd};
      home_s_q <= {home_s_q[0], home_sensor};
      lock_s_q <= {lock_s_q[0], autostart_lockout};
    end
  end

  // serial receiver, 8N1, sampled mid-bit
  logic rx_act_q, rx_act_d, rx_vld_q, rx_vld_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  always_comb begin
    rx_act_d = rx_act_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_byte_d = rx_byte_q;
    rx_vld_d = 1'b0;
    if (!rx_act_q) begin
      if (!rx_s_q[1]) begin
        rx_act_d = 1'b1;
        rx_cnt_d = BAUD_DIV >> 1;
        rx_bit_d = 4'h0;
      end
    end else if (rx_cnt_q != 16'h0000) begin
      rx_cnt_d = rx_cnt_q - 16'h0001;
    end else begin
      rx_cnt_d = BAUD_DIV - 16'h0001;
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0) begin
        rx_act_d = !rx_s_q[1];
      end else if (rx_bit_q <= 4'h8) begin
        rx_sh_d = {rx_s_q[1], rx_sh_q[7:1]};
      end else begin
        rx_act_d = 1'b0;
        rx_vld_d = 1'b1;
        rx_byte_d = rx_sh_q;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_vld_q <= 1'b0;
    end else begin
      rx_act_q <= rx_act_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_byte_q <= rx_byte_d;
      rx_vld_q <= rx_vld_d;
    end
  end

  // serial transmitter, eleven shifts so the stop bit lasts a full bit
  logic tx_go;
  logic [7:0] tx_char;
  logic tx_q, tx_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_n_q, tx_n_d;
  always_comb begin
    tx_d = tx_q;
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    tx_n_d = tx_n_q;
    if (tx_n_q != 4'h0) begin
      if (tx_cnt_q != 16'h0000) begin
        tx_cnt_d = tx_cnt_q - 16'h0001;
      end else begin
        tx_cnt_d = BAUD_DIV - 16'h0001;
        tx_d = tx_sh_q[0];
        tx_sh_d = {1'b1, tx_sh_q[9:1]};
        tx_n_d = tx_n_q - 4'h1;
      end
    end else if (tx_go) begin
      tx_sh_d = {1'b1, tx_char, 1'b0};
      tx_n_d = 4'hB;
      tx_cnt_d = 16'h0000;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 1'b1;
      tx_sh_q <= 10'h3FF;
      tx_cnt_q <= 16'h0000;
      tx_n_q <= 4'h0;
    end else begin
      tx_q <= tx_d;
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      tx_n_q <= tx_n_d;
    end
  end
  assign txd = tx_q;

  // command sequencer, line parser and motion
  logic [31:0] ctrl_q;
  logic [PER_W-1:0] start_q, top_q, accel_q;
  logic [EV_W-1:0] ev;
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, fch;
  logic fvld;
  logic [POS_W-1:0] val;
  msci_state_t st_q, st_d, ret;
  msci_reply_t kind_q, kind_d;
  logic run_q, run_d, clr_q, clr_d, got_q, got_d, num_q, num_d;
  logic hexf_q, hexf_d, pend_q, pend_d, auto_q, auto_d, sub_q, sub_d;
  logic drv_n_q, drv_n_d, dir_q, dir_d, step_q, step_d;
  logic [7:0] cmd_q, cmd_d, argl_q, argl_d, hex_q, hex_d, mode_q, mode_d;
  logic [POS_W-1:0] dec_q, dec_d, pos_q, pos_d, tgt_q, tgt_d;
  logic [POS_W-1:0] cv_q, cv_d;
  logic [MEM_AW-1:0] ptr_q, ptr_d, cnt_q, cnt_d;
  logic [PER_W-1:0] per_q, per_d, tick_q, tick_d, pw_q, pw_d;
  logic [2:0] k_q, k_d;
  logic [4*7-1:0] dig_q, dig_d;
  logic [3:0] idx_q, idx_d;

  msci_mem u_mem (
    .clk(pclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign val = hexf_q ? {16'h0000, hex_q} : dec_q;
  assign ret = run_q ? ST_RUN : ST_IDLE;
  assign tx_char = reply_char(kind_q, idx_q, dig_q);
  assign tx_go = (st_q == ST_SEND) && (tx_n_q == 4'h0);

  always_comb begin
    {st_d, kind_d, run_d, clr_d, got_d, num_d} =
      {st_q, kind_q, run_q, clr_q, got_q, num_q};
    {hexf_d, pend_d, auto_d, sub_d, drv_n_d, dir_d} =
      {hexf_q, pend_q, auto_q, sub_q, drv_n_q, dir_q};
    {cmd_d, argl_d, hex_d, mode_d, dec_d, pos_d, tgt_d, cv_d} =
      {cmd_q, argl_q, hex_q, mode_q, dec_q, pos_q, tgt_q, cv_q};
    {ptr_d, cnt_d, per_d, tick_d, k_d, dig_d, idx_d} =
      {ptr_q, cnt_q, per_q, tick_q, k_q, dig_q, idx_q};
    pw_d = (pw_q != 16'h0000) ? pw_q - 16'h0001 : pw_q;
    ev = '0;
    fvld = 1'b0;
    fch = rx_byte_q;
    mem_we = 1'b0;
    mem_addr = ptr_q;
    mem_wdata = rx_byte_q;
    // characters arriving while busy are dropped and flagged
    if (rx_vld_q && st_q != ST_IDLE) begin
      ev[EV_LOST] = 1'b1;
    end
    unique case (st_q)
      ST_BOOT: begin
        cnt_d = cnt_q + 11'h001;
        if (cnt_q == BOOT_WAIT) begin
          cnt_d = '0;
          auto_d = 1'b1;
          st_d = lock_s_q[1] ? ST_IDLE : ST_FLAGS;
        end
      end
      ST_FLAGS: begin
        mem_addr = cnt_q;
        cnt_d = cnt_q + 11'h001;
        // any cleared flag byte disarms auto-start
        if (cnt_q != '0 && mem_rdata == CH_NUL) begin
          auto_d = 1'b0;
        end
        if (cnt_q == FLAG_LAST) begin
          st_d = ST_IDLE;
          if (auto_d) begin
            ptr_d = PROG_START;
            run_d = 1'b1;
            sub_d = 1'b0;
            st_d = ST_RUN;
          end
        end
      end
      ST_IDLE: begin
        if (rx_vld_q && ctrl_q[0]) begin
          mem_we = 1'b1;
          ptr_d = ptr_q + 11'h001;
        end else if (rx_vld_q) begin
          fvld = 1'b1;
          if (rx_byte_q == CH_CR) begin
            st_d = ST_EXEC;
          end
        end
      end
      ST_RUN: begin
        sub_d = !sub_q;
        if (sub_q) begin
          fch = mem_rdata;
          ptr_d = ptr_q + 11'h001;
          if (mem_rdata == CH_NUL) begin
            run_d = 1'b0;
            st_d = ST_IDLE;
          end else begin
            fvld = 1'b1;
            if (mem_rdata == CH_CR) begin
              st_d = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC: begin
        {clr_d, got_d, num_d, hexf_d} = 4'h0;
        {dec_d, hex_d, argl_d, cmd_d} = '0;
        pend_d = 1'b0;
        ev[EV_DONE] = 1'b1;
        st_d = ret;
        tick_d = '0;
        per_d = start_q;
        dig_d = '0;
        k_d = '0;
        idx_d = 4'h0;
        sub_d = 1'b0;
        if (!got_q && num_q && val == '0) begin
          run_d = 1'b0;
          st_d = ST_IDLE;
        end else if (cmd_q == CH_B && val == ENABLE_BIT) begin
          drv_n_d = !clr_q;
        end else if (cmd_q == CH_H && val == HOME_BIT) begin
          dir_d = 1'b0;
          st_d = ST_HOME;
        end else if (cmd_q == CH_P && num_q) begin
          tgt_d = val;
          // signed compare: homing can leave the counter below zero
          dir_d = $signed(val) > $signed(pos_q);
          st_d = (val == pos_q) ? ret : ST_MOVE;
        end else if (cmd_q == CH_Y && num_q) begin
          ptr_d = val[MEM_AW-1:0];
        end else if (cmd_q == CH_Y && pend_q) begin
          cnt_d = '0;
          st_d = ST_ERASE;
        end else if (cmd_q == CH_C) begin
          pend_d = 1'b1;
        end else if (cmd_q == CH_O && num_q) begin
          mode_d = val[7:0];
        end else if (cmd_q == CH_X) begin
          run_d = 1'b1;
          st_d = ST_RUN;
        end else if (cmd_q == CH_Q && argl_q == CH_P) begin
          cv_d = pos_q;
          kind_d = RK_POS;
          st_d = ST_CONV;
        end else if (cmd_q == CH_Q && argl_q == CH_Y) begin
          cv_d = {13'h0000, ptr_q};
          kind_d = RK_PTR;
          st_d = ST_CONV;
        end
      end
      ST_CONV: begin
        // repeated subtraction, one digit per power of ten
        if (k_q == DIG_N) begin
          st_d = ST_SEND;
        end else if (cv_q >= pow10(k_q)) begin
          cv_d = cv_q - pow10(k_q);
          dig_d[{k_q, 2'b00} +: 4] = dig_q[{k_q, 2'b00} +: 4] + 4'h1;
        end else begin
          k_d = k_q + 3'h1;
        end
      end
      ST_SEND: begin
        if (tx_go) begin
          idx_d = idx_q + 4'h1;
          if (tx_char == CH_CR) begin
            st_d = ret;
          end
        end
      end
      ST_ERASE: begin
        mem_we = 1'b1;
        mem_addr = cnt_q;
        mem_wdata = cnt_q[0] ? CH_CR : CH_0;
        cnt_d = cnt_q + 11'h001;
        if (cnt_q == MEM_LAST) begin
          ptr_d = '0;
          ev[EV_ERASE] = 1'b1;
          kind_d = RK_DONE;
          st_d = ST_SEND;
        end
      end
      ST_MOVE, ST_HOME: begin
        if (tick_q != '0) begin
          tick_d = tick_q - 16'h0001;
        end else if (st_q == ST_HOME && !home_s_q[1]) begin
          ev[EV_HOME] = 1'b1;
          st_d = ret;
        end else if (st_q == ST_MOVE && pos_q == tgt_q) begin
          st_d = ret;
        end else begin
          pos_d = dir_q ? pos_q + 24'h000001 : pos_q - 24'h000001;
          tick_d = per_q - 16'h0001;
          per_d = next_per(per_q, top_q, accel_q);
          pw_d = STEP_PULSE_CYC;
        end
      end
    endcase
    // line parser: optional slash, letter, spaced arguments
    if (fvld && fch != CH_CR && fch != CH_SP) begin
      if (fch >= CH_0 && fch <= CH_9) begin
        dec_d = dec_q * 24'h00000A + {16'h0000, fch - CH_0};
        hex_d = {hex_q[3:0], fch[3:0]};
        num_d = 1'b1;
      end else if (!got_q && fch == CH_SLASH) begin
        clr_d = 1'b1;
      end else if (!got_q) begin
        cmd_d = fch;
        got_d = 1'b1;
      end else if (fch == CH_H && num_q) begin
        hexf_d = 1'b1;
      end else begin
        argl_d = fch;
      end
    end
    step_d = pw_d != 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {st_q, kind_q} <= {ST_BOOT, RK_POS};
      {run_q, clr_q, got_q, num_q, hexf_q, pend_q, auto_q, sub_q} <= '0;
      {drv_n_q, dir_q, step_q} <= 3'b100;
      {cmd_q, argl_q, hex_q, mode_q} <= '0;
      {dec_q, pos_q, tgt_q, cv_q} <= '0;
      {ptr_q, cnt_q, per_q, tick_q, pw_q} <= '0;
      {k_q, dig_q, idx_q} <= '0;
      {ready_busy, busy_bit} <= 2'b11;
    end else begin
      {st_q, kind_q} <= {st_d, kind_d};
      {run_q, clr_q, got_q, num_q, hexf_q, pend_q, auto_q, sub_q} <=
        {run_d, clr_d, got_d, num_d, hexf_d, pend_d, auto_d, sub_d};
      {drv_n_q, dir_q, step_q} <= {drv_n_d, dir_d, step_d};
      {cmd_q, argl_q, hex_q, mode_q} <= {cmd_d, argl_d, hex_d, mode_d};
      {dec_q, pos_q, tgt_q, cv_q} <= {dec_d, pos_d, tgt_d, cv_d};
      {ptr_q, cnt_q, per_q, tick_q, pw_q} <=
        {ptr_d, cnt_d, per_d, tick_d, pw_d};
      {k_q, dig_q, idx_q} <= {k_d, dig_d, idx_d};
      ready_busy <= st_d != ST_IDLE;
      busy_bit <= (st_d != ST_IDLE) && mode_d[MODE_BUSY];
    end
  end
  assign step = step_q;
  assign dir_cw = dir_q;
  assign drv_enable_n = drv_n_q;

  // apb slave: answer one cycle into the access phase
  logic [31:0] ctrl_d, prdata_d;
  logic [PER_W-1:0] start_d, top_d, accel_d;
  logic [EV_W-1:0] ist_q, ist_d, imsk_q, imsk_d;
  logic pready_d, pslverr_d, irq_d, wr;
  always_comb begin
    {ctrl_d, start_d, top_d, accel_d, imsk_d} =
      {ctrl_q, start_q, top_q, accel_q, imsk_q};
    pready_d = psel && penable && !pready;
    wr = psel && penable && pready && pwrite;
    ist_d = ist_q;
    pslverr_d = 1'b0;
    prdata_d = '0;
    case (paddr)
      A_CTRL: prdata_d = ctrl_q;
      A_STATUS: prdata_d = {20'h00000, run_q, !drv_n_q,
                            ready_busy, 1'b0, mode_q};
      A_POS: prdata_d = {8'h00, pos_q};
      A_PTR: prdata_d = {21'h000000, ptr_q};
      A_START: prdata_d = {16'h0000, start_q};
      A_TOP: prdata_d = {16'h0000, top_q};
      A_ACCEL: prdata_d = {16'h0000, accel_q};
      A_IRQ_ST: prdata_d = {28'h0000000, ist_q};
      A_IRQ_MSK: prdata_d = {28'h0000000, imsk_q};
      default: pslverr_d = pready_d;
    endcase
    if (wr) begin
      case (paddr)
        A_CTRL: ctrl_d = {31'h00000000, pwdata[0]};
        A_START: start_d = pwdata[PER_W-1:0];
        A_TOP: top_d = pwdata[PER_W-1:0];
        A_ACCEL: accel_d = pwdata[PER_W-1:0];
        A_IRQ_ST: ist_d = ist_q & ~pwdata[EV_W-1:0];
        A_IRQ_MSK: imsk_d = pwdata[EV_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imsk_d);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      start_q <= START_RST;
      top_q <= TOP_RST;
      accel_q <= ACCEL_RST;
      {ist_q, imsk_q} <= '0;
      {prdata, pready, pslverr, irq} <= '0;
    end else begin
      {ctrl_q, start_q, top_q, accel_q} <=
        {ctrl_d, start_d, top_d, accel_d};
      {ist_q, imsk_q} <= {ist_d, imsk_d};
      {prdata, pready, pslverr, irq} <=
        {prdata_d, pready_d, pslverr_d, irq_d};
    end
  end
endmodule
`default_nettype wire

// File: verif/msci_host.sv
// host computer model on the serial link
`timescale 1ns/1ns
`default_nettype none
module msci_host #(
  parameter int DIV = 16
) (
  input wire logic pclk,
  input wire logic ready_busy,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rxq[$];
  initial rxd = 1'b1;
  // every line ends in a carriage return
  task automatic put_line(input string s);
    logic [9:0] f;
    for (int i = 0; i <= s.len(); i++) begin
      f = {1'b1, (i == s.len()) ? 8'h0D : 8'(s[i]), 1'b0};
      while (ready_busy !== 1'b0) @(posedge pclk);
      repeat (DIV) @(posedge pclk);
      for (int b = 0; b < 10; b++) begin
        rxd <= f[b];
        repeat (DIV) @(posedge pclk);
      end
    end
  endtask
  // mid-bit sampling, lsb first
  always begin : rx_loop
    logic [7:0] c;
    @(negedge txd);
    repeat (DIV / 2) @(posedge pclk);
    for (int b = 0; b < 8; b++) begin
      repeat (DIV) @(posedge pclk);
      c[b] = txd;
    end
    repeat (DIV) @(posedge pclk);
    rxq.push_back(c);
  end
endmodule
`default_nettype wire

// File: verif/msci_checker.sv
// port-level assertions for the interpreter top
`timescale 1ns/1ns
`default_nettype none
module msci_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ready_busy,
  input wire logic busy_bit,
  input wire logic step,
  input wire logic dir_cw
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [8:0] hi_q, hi_d;
  always_comb hi_d = step ? hi_q + 9'h001 : 9'h000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_q <= 9'h000;
    else hi_q <= hi_d;
  end
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  access_two_a: assert property ($rose(penable) && psel |-> s_answer)
    else $error("access phase not two cycles");
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  nomap_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  busy_bit_a: assert property (busy_bit |-> ready_busy)
    else $error("busy bit while idle");
  step_busy_a: assert property (step |-> ready_busy)
    else $error("step while ready low");
  step_width_a: assert property ($fell(step) |-> hi_q == 9'h0FA)
    else $error("step pulse width");
  dir_hold_a: assert property (step && $past(step) |-> $stable(dir_cw))
    else $error("direction moved in a step");
endmodule
bind msci_top msci_checker i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .ready_busy, .busy_bit, .step,
  .dir_cw);
`default_nettype wire

// File: verif/msci_top_tb.sv
// self-checking bench for the serial motion command interpreter
`timescale 1ns/1ns
`default_nettype none
module msci_top_tb;
  import msci_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, home_sensor = 1'b1, autostart_lockout = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rxd, txd, ready_busy, busy_bit, step, dir_cw;
  logic drv_enable_n, irq, er;
  int err_total = 0, n_compared = 0, n_steps = 0, n0;
  msci_top #(.BAUD_DIV(16'h0010)) i_dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd,
    .ready_busy, .busy_bit, .home_sensor, .autostart_lockout, .step,
    .dir_cw, .drv_enable_n, .irq);
  msci_host #(.DIV(16)) i_host (.pclk, .ready_busy, .txd, .rxd);
  initial forever #4 pclk = ~pclk;
  always @(posedge step) n_steps++;
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic chk_str(input string s);
    string g;
    for (int i = 0; i < 20000 && !(i_host.rxq.size() > s.len()
        && i_host.rxq[$] == CH_CR); i++) @(posedge pclk);
    g = "";
    foreach (i_host.rxq[i]) g = {g, string'(i_host.rxq[i])};
    n_compared++;
    if (g != {s, "\r"}) begin
      $display("[ERR] reply exp %s got %s", s, g);
      err_total++;
    end
    i_host.rxq.delete();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 40000 && ready_busy !== 1'b0; i++) @(posedge pclk);
    chk("ready_busy", 32'h0, 32'(ready_busy));
  endtask
  task automatic cmd(input string s);
    i_host.put_line(s);
    idle;
  endtask
  task automatic rst(input logic lk);
    autostart_lockout <= lk;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic t_regs;
    apb(1'b0, A_START, 32'h0);
    chk("start", 32'(START_RST), rd);
    apb(1'b0, A_TOP, 32'h0);
    chk("top", 32'(TOP_RST), rd);
    apb(1'b0, A_ACCEL, 32'h0);
    chk("accel", 32'(ACCEL_RST), rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    // short periods keep moves quick but above the 250-cycle pulse
    apb(1'b1, A_START, 32'h190);
    apb(1'b1, A_TOP, 32'h12C);
    apb(1'b1, A_ACCEL, 32'h32);
  endtask
  task automatic t_enable;
    chk("drv reset", 32'h1, 32'(drv_enable_n));
    cmd("/B 0");
    chk("drv on", 32'h0, 32'(drv_enable_n));
    cmd("B 0");
    chk("drv free", 32'h1, 32'(drv_enable_n));
    cmd("/B 0");
  endtask
  task automatic t_mode;
    cmd("O 80H");
    i_host.put_line("P 1");
    repeat (10) @(posedge pclk);
    chk("busy_bit", 32'h1, 32'(busy_bit));
    idle;
  endtask
  task automatic t_move;
    n0 = n_steps;
    cmd("P 5");
    chk("steps up", 32'h4, 32'(n_steps - n0));
    chk("dir cw", 32'h1, 32'(dir_cw));
    cmd("? P");
    chk_str("P=0000005");
    n0 = n_steps;
    cmd("P 0");
    chk("steps down", 32'h5, 32'(n_steps - n0));
    chk("dir ccw", 32'h0, 32'(dir_cw));
    apb(1'b0, A_POS, 32'h0);
    chk("pos", 32'h0, rd);
  endtask
  task automatic t_home;
    n0 = n_steps;
    i_host.put_line("H 1");
    for (int i = 0; i < 20000 && n_steps < n0 + 3; i++) @(posedge pclk);
    home_sensor <= 1'b0;
    idle;
    chk("home steps", 32'h3, 32'(n_steps - n0));
    home_sensor <= 1'b1;
    cmd("P 0");
    apb(1'b0, A_POS, 32'h0);
    chk("pos origin", 32'h0, rd);
  endtask
  task automatic t_ptr;
    cmd("Y 3");
    cmd("? Y");
    chk_str("Y=0003");
  endtask
  task automatic t_erase;
    cmd("CLEAR");
    i_host.rxq.delete();
    cmd("Y");
    chk_str("DONE");
    apb(1'b0, A_PTR, 32'h0);
    chk("ptr erased", 32'h0, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, A_IRQ_MSK, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, A_IRQ_ST, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask
  task automatic t_prog;
    cmd("Y 3");
    apb(1'b1, A_CTRL, 32'h1);
    cmd("P 2");
    cmd("0");
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b0, A_PTR, 32'h0);
    chk("ptr stored", 32'h9, rd);
    cmd("Y 3");
    n0 = n_steps;
    cmd("X");
    chk("run steps", 32'h2, 32'(n_steps - n0));
    cmd("Y 0");
    apb(1'b1, A_CTRL, 32'h1);
    cmd("111P 2"); // flags at bytes 0..2
    apb(1'b1, A_CTRL, 32'h0);
    rst(1'b1);
    repeat (30) @(posedge pclk);
    chk("lockout", 32'h0, 32'(ready_busy));
    rst(1'b0);
    repeat (30) @(posedge pclk);
    chk("autostart", 32'h1, 32'(ready_busy));
    idle;
  endtask
  initial begin
    // memory is unknown at power-up, so keep auto-start locked out
    rst(1'b1);
    t_regs;
    t_enable;
    t_mode;
    t_move;
    t_home;
    t_ptr;
    t_erase;
    t_prog;
    tally_and_finish;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
